/* fhi_checker.sv */
// Purpose: port assertions for fhi_top
// Assumes: doc bit n sits at vector index 11-n
// Notes:   bound into every fhi_top instance
`timescale 1ns/10ps
module fhi_checker (
  input wire        clk_i,
  input wire        reset_i,
  input wire        iot_strobe_i,
  input wire [2:0]  iot_code_i,
  input wire [11:0] ac_i,
  input wire [11:0] ac_o,
  input wire        ac_load_o,
  input wire        skip_o,
  input wire        irq_o,
  input wire        ctl_dir_out_i,
  input wire        ctl_fn_end_i,
  input wire        ctl_read_status_i,
  input wire        ctl_parity_err_i,
  input wire        ctl_proceed_o,
  input wire        ctl_cmd_o,
  input wire        ctl_mode8_o,
  input wire [11:0] ifr_o,
  input wire [11:0] status_o,
  input wire        status_valid_o,
  input wire        pwr_ok_i,
  input wire        head_load_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_move_in:
  assert property (ac_load_o |-> $past(iot_strobe_i) && $past(iot_code_i) == 3'h2 && ac_o ==
    (ctl_mode8_o ? ($past(ac_i) | ($past(ifr_o) & 12'h0FF)) : $past(ifr_o)))
    else $error("bad word into accumulator");
  a_ac_kept:
  assert property (ctl_proceed_o && !$past(ctl_dir_out_i) |-> ac_o == $past(ac_i)
    && ifr_o == $past(ac_i)) else $error("outgoing word altered");
  a_cmd_cause:
  assert property (ctl_cmd_o |-> $past(iot_code_i) == 3'h1 && ifr_o == $past(ac_i))
    else $error("command not from accumulator");
  a_skip_cause:
  assert property (skip_o |-> $past(iot_strobe_i) && $past(iot_code_i) >= 3'h3
    && $past(iot_code_i) <= 3'h5) else $error("skip without skip instruction");
  a_irq_skipclr:
  assert property (skip_o && $past(iot_code_i) == 3'h5 |=> !irq_o)
    else $error("irq stays after done cleared");
  a_irq_disable:
  assert property ($past(iot_strobe_i) && $past(iot_code_i) == 3'h6 && !$past(ac_i[0])
    |=> !irq_o) else $error("irq after disable");
  a_parity_stat:
  assert property ($past(ctl_fn_end_i) && $past(ctl_parity_err_i) && status_valid_o
    |-> status_o[1] && ifr_o == status_o) else $error("parity status missing");
  a_rdstat_mask:
  assert property ($past(ctl_fn_end_i) && $past(ctl_read_status_i) && status_valid_o
    |-> !ifr_o[2]) else $error("init bit in read status");
  a_power_inval:
  assert property (!pwr_ok_i [*3] |=> !status_valid_o && !head_load_o)
    else $error("status valid while power low");
endmodule // fhi_checker
bind fhi_top fhi_checker fhi_checker_i (.clk_i, .reset_i, .iot_strobe_i, .iot_code_i,
  .ac_i, .ac_o, .ac_load_o, .skip_o, .irq_o, .ctl_dir_out_i, .ctl_fn_end_i,
  .ctl_read_status_i, .ctl_parity_err_i, .ctl_proceed_o, .ctl_cmd_o, .ctl_mode8_o,
  .ifr_o, .status_o, .status_valid_o, .pwr_ok_i, .head_load_o);

/* fhi_defines.vh */
// Purpose: shared constants of the floppy host interface
// Assumes: 12-bit words; doc bit n sits at vector index 11-n
// Notes:   only definitions, no logic
`ifndef FHI_DEFINES_VH
`define FHI_DEFINES_VH

// Low octal digit of the 675x instruction codes
`define FHI_IOT_LOAD_CMD    3'h1
`define FHI_IOT_MOVE_WORD   3'h2
`define FHI_IOT_SKIP_WREQ   3'h3
`define FHI_IOT_SKIP_ERR    3'h4
`define FHI_IOT_SKIP_DONE   3'h5
`define FHI_IOT_IRQ_ENABLE  3'h6
`define FHI_IOT_INIT        3'h7

// Error-status word fields (vector index)
`define FHI_ST_CRC          0
`define FHI_ST_PARITY       1
`define FHI_ST_INIT_DONE    2
`define FHI_ST_DELETED      6
`define FHI_ST_READY        7
`define FHI_STATUS_RESET    12'h000

// AC bit 11 steers the interrupt enable
`define FHI_AC_IE_BIT       0
// Command word bit 6 selects 8-bit mode
`define FHI_CMD_MODE8_BIT   5

// Initialize sequence targets
`define FHI_SEEK_UNIT       1'h1
`define FHI_SEEK_TRACK      7'h00
`define FHI_READ_UNIT       1'h0
`define FHI_READ_TRACK      7'h01
`define FHI_READ_SECTOR     5'h01

// Timing
`define FHI_CLK_HZ          20000000
`define FHI_INIT_TIME_MS    1800

`endif

/* fhi_mech_model.sv */
// Purpose: drive mechanism stand-in for fhi_top
// Assumes: every seek or read answers after DLY cycles, ok unless fail_cfg_i
// Notes:   ok only qualifies the done pulse
`timescale 1ns/10ps
module fhi_mech_model #(
  parameter integer DLY = 10
) (
  input  wire clk_i,
  input  wire reset_i,
  input  wire ready_cfg_i,
  input  wire present_cfg_i,
  input  wire fail_cfg_i,
  input  wire mech_seek_o,
  input  wire mech_read_o,
  output reg  mech_done_i,
  output reg  mech_ok_i,
  output wire drive_ready_i,
  output wire drv1_present_i
);
  integer cnt;
  assign drive_ready_i  = ready_cfg_i;
  assign drv1_present_i = present_cfg_i;
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt         <= 0;
      mech_done_i <= 1'b0;
      mech_ok_i   <= 1'b0;
    end else begin
      mech_done_i <= (cnt == 1);
      mech_ok_i   <= (cnt == 1) & ~fail_cfg_i;
      if (mech_seek_o || mech_read_o) cnt <= DLY;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule // fhi_mech_model

/* fhi_top.v */
// Purpose: processor-side port of the floppy drive system with status,
//          flags and the initialize / power-return sequencer
// Assumes: processor and controller logic share clk_i; pwr_ok_i,
//          drive_ready_i and drv1_present_i are pins
// Notes:   skip/AC answers are one-cycle pulses one edge after the strobe
//
// Behaviour
// RULE_01 - Power loss unloads head, aborts, invalidates status
// RULE_02 - Power return: drop done, init, set done
// RULE_03 - Move-word transfers word; drive direction decides
// RULE_04 - Word width follows 8 or 12-bit mode
// RULE_05 - Move-word while not done tells drive proceed
// RULE_06 - Outgoing word leaves AC unchanged
// RULE_07 - Incoming word jams 12 bits or ORs 8
// RULE_08 - When done, move-word returns status word
// RULE_09 - Skip on word request, then clear it
// RULE_10 - Software tests word request before each transfer
// RULE_11 - Skip on error, then clear error flag
// RULE_12 - Setting error also sets done
// RULE_13 - Status word loaded at every function end
// RULE_14 - Bit 11 flags CRC failure
// RULE_15 - Parity error: bit 10, terminate, error+done
// RULE_16 - Bit 9 marks init done, hidden in read-status
// RULE_17 - Bit 5 marks deleted mark or write-deleted
// RULE_18 - Bit 4 means selected drive truly ready
// RULE_19 - Skip on done clears done; done interrupts
// RULE_20 - AC bit 11 enables or disables interrupt
// RULE_21 - Initialize: seek, read, zero status, done
// RULE_22 - Software retries CRC errors up to ten
// RULE_23 - Sector then track address requested by flag
// RULE_24 - Interrupt is done AND enable
`timescale 1ns/10ps
`include "fhi_defines.vh"

module fhi_top #(
  parameter integer INIT_CYC = `FHI_INIT_TIME_MS * (`FHI_CLK_HZ / 1000)
) (
  input  wire        clk_i,
  input  wire        reset_i,
  // Processor instruction side
  input  wire        iot_strobe_i,
  input  wire [2:0]  iot_code_i,
  input  wire [11:0] ac_i,
  output reg  [11:0] ac_o,
  output reg         ac_load_o,
  output reg         skip_o,
  output reg         irq_o,
  // Drive controller side
  input  wire        ctl_word_req_i,
  input  wire        ctl_dir_out_i,
  input  wire        ctl_word_load_i,
  input  wire [11:0] ctl_word_i,
  input  wire        ctl_fn_start_i,
  input  wire        ctl_clr_deleted_i,
  input  wire        ctl_fn_end_i,
  input  wire        ctl_read_status_i,
  input  wire        ctl_crc_err_i,
  input  wire        ctl_parity_err_i,
  input  wire        ctl_deleted_i,
  input  wire        ctl_fail_i,
  output reg         ctl_proceed_o,
  output reg         ctl_cmd_o,
  output reg         ctl_mode8_o,
  output reg         ctl_abort_o,
  output reg  [11:0] ifr_o,
  output reg  [11:0] status_o,
  output reg         status_valid_o,
  // Mechanism side
  input  wire        pwr_ok_i,
  input  wire        drive_ready_i,
  input  wire        drv1_present_i,
  input  wire        mech_done_i,
  input  wire        mech_ok_i,
  output reg         head_load_o,
  output reg         mech_seek_o,
  output reg         mech_read_o,
  output reg         mech_unit_o,
  output reg  [6:0]  mech_track_o,
  output reg  [4:0]  mech_sector_o
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_SEEK  = 3'h1;
  localparam [2:0] S_SEEKW = 3'h2;
  localparam [2:0] S_READ  = 3'h3;
  localparam [2:0] S_READW = 3'h4;
  localparam [2:0] S_FIN   = 3'h5;

  reg  [1:0]  pwr_s_q;
  reg  [1:0]  rdy_s_q;
  reg  [1:0]  d1_s_q;
  reg         pwr_prev_q;
  reg         tr_q;
  reg         err_q;
  reg         done_q;
  reg         ie_q;
  reg  [2:0]  st_q;
  reg  [31:0] tmo_q;

  wire pwr_ok   = pwr_s_q[1];
  wire pwr_rise = pwr_ok & ~pwr_prev_q;
  wire iot      = iot_strobe_i & pwr_ok;
  // Maintenance mode is never entered by this port
  wire maint_q  = 1'b0;
  wire do_load  = iot & (iot_code_i == `FHI_IOT_LOAD_CMD);
  wire do_move  = iot & (iot_code_i == `FHI_IOT_MOVE_WORD) & ~maint_q;
  wire do_str   = iot & (iot_code_i == `FHI_IOT_SKIP_WREQ);
  wire do_ser   = iot & (iot_code_i == `FHI_IOT_SKIP_ERR);
  wire do_sdn   = iot & (iot_code_i == `FHI_IOT_SKIP_DONE);
  wire do_ie    = iot & (iot_code_i == `FHI_IOT_IRQ_ENABLE);
  wire do_init  = iot & (iot_code_i == `FHI_IOT_INIT);

  // RULE_08 status read-back
  wire to_ac    = done_q | ctl_dir_out_i;
  wire busy     = (st_q != S_IDLE);
  wire init_go  = do_init | pwr_rise;
  wire init_end = (st_q == S_FIN);
  wire timeout  = busy & (tmo_q >= INIT_CYC - 1);

  // Status word assembled at function end
  reg  [11:0] fn_status;
  always @* begin
    fn_status = status_o;
    // RULE_14 CRC bit
    if (ctl_crc_err_i)
      fn_status[`FHI_ST_CRC] = 1'b1;
    // RULE_15 parity bit
    if (ctl_parity_err_i)
      fn_status[`FHI_ST_PARITY] = 1'b1;
    // RULE_17 deleted mark
    if (ctl_deleted_i)
      fn_status[`FHI_ST_DELETED] = 1'b1;
    // RULE_18 ready bit
    fn_status[`FHI_ST_READY] = rdy_s_q[1];
  end

  // RULE_16 hidden from read-status
  wire [11:0] fn_word = ctl_read_status_i ?
                        (fn_status & ~(12'h001 << `FHI_ST_INIT_DONE)) : fn_status;
  wire fn_bad = ctl_crc_err_i | ctl_parity_err_i | ctl_fail_i;

  // Pin synchronisers
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_s_q    <= 2'h0;
      rdy_s_q    <= 2'h0;
      d1_s_q     <= 2'h0;
      pwr_prev_q <= 1'b0;
    end else begin
      pwr_s_q    <= {pwr_s_q[0], pwr_ok_i};
      rdy_s_q    <= {rdy_s_q[0], drive_ready_i};
      d1_s_q     <= {d1_s_q[0], drv1_present_i};
      pwr_prev_q <= pwr_ok;
    end
  end

  // Flags: a set in the clearing cycle wins
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tr_q   <= 1'b0;
      err_q  <= 1'b0;
      done_q <= 1'b0;
      ie_q   <= 1'b0;
    end else if (!pwr_ok) begin
      tr_q   <= 1'b0;
      err_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      // RULE_09 clear word request
      if (do_str)
        tr_q <= 1'b0;
      // RULE_23 address requests
      if (ctl_word_req_i)
        tr_q <= 1'b1;
      // RULE_11 clear error
      if (do_ser)
        err_q <= 1'b0;
      // RULE_19 clear done
      if (do_sdn)
        done_q <= 1'b0;
      // RULE_02 drop done first
      if (init_go)
        done_q <= 1'b0;
      if (ctl_fn_end_i | init_end)
        done_q <= 1'b1;
      // RULE_12 error forces done
      if ((ctl_fn_end_i & fn_bad) | timeout) begin
        err_q  <= 1'b1;
        done_q <= 1'b1;
      end
      // RULE_20 enable from AC 11
      if (do_ie)
        ie_q <= ac_i[`FHI_AC_IE_BIT];
    end
  end

  // Processor answers
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ac_o          <= 12'h000;
      ac_load_o     <= 1'b0;
      skip_o        <= 1'b0;
      irq_o         <= 1'b0;
      ctl_proceed_o <= 1'b0;
      ctl_cmd_o     <= 1'b0;
      ctl_mode8_o   <= 1'b0;
    end else begin
      ac_load_o     <= 1'b0;
      ctl_cmd_o     <= do_load;
      // RULE_05 proceed only while not done
      ctl_proceed_o <= do_move & ~done_q;
      skip_o        <= (do_str & tr_q) | (do_ser & err_q) | (do_sdn & done_q);
      // RULE_24 done AND enable
      irq_o         <= done_q & ie_q & pwr_ok;
      if (do_load)
        ctl_mode8_o <= ac_i[`FHI_CMD_MODE8_BIT];
      // RULE_03 direction from drive
      if (do_move & to_ac) begin
        ac_load_o <= 1'b1;
        // RULE_07 jam or OR
        if (ctl_mode8_o)
          ac_o <= {ac_i[11:8], ac_i[7:0] | ifr_o[7:0]};
        else
          ac_o <= ifr_o;
      end else begin
        // RULE_06 AC unchanged
        ac_o <= ac_i;
      end
    end
  end

  // Interface register and status word
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ifr_o    <= 12'h000;
      status_o <= `FHI_STATUS_RESET;
    end else if (pwr_ok) begin
      if (ctl_fn_start_i) begin
        status_o[`FHI_ST_CRC]    <= 1'b0;
        status_o[`FHI_ST_PARITY] <= 1'b0;
        if (ctl_clr_deleted_i)
          status_o[`FHI_ST_DELETED] <= 1'b0;
      end
      if (ctl_word_load_i)
        ifr_o <= ctl_word_i;
      // RULE_04 whole word kept, drive uses mode
      if (do_move & ~to_ac)
        ifr_o <= ac_i;
      if (do_load)
        ifr_o <= ac_i;
      // RULE_13 status at function end
      if (ctl_fn_end_i) begin
        status_o <= fn_word;
        ifr_o    <= fn_word;
      end
      // RULE_21 zero status on initialize
      if (init_go)
        status_o <= `FHI_STATUS_RESET;
      if (init_end | timeout) begin
        status_o <= {status_o[11:8], rdy_s_q[1], status_o[6:3],
                     init_end, status_o[1:0]};
        ifr_o    <= {status_o[11:8], rdy_s_q[1], status_o[6:3],
                     init_end, status_o[1:0]};
      end
    end
  end

  // Initialize / power-return sequencer
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q           <= S_IDLE;
      tmo_q          <= 32'h00000000;
      head_load_o    <= 1'b0;
      ctl_abort_o    <= 1'b0;
      status_valid_o <= 1'b0;
      mech_seek_o    <= 1'b0;
      mech_read_o    <= 1'b0;
      mech_unit_o    <= 1'b0;
      mech_track_o   <= 7'h00;
      mech_sector_o  <= 5'h00;
    end else if (!pwr_ok) begin
      // RULE_01 unload and abort
      st_q           <= S_IDLE;
      tmo_q          <= 32'h00000000;
      head_load_o    <= 1'b0;
      ctl_abort_o    <= 1'b1;
      status_valid_o <= 1'b0;
      mech_seek_o    <= 1'b0;
      mech_read_o    <= 1'b0;
    end else begin
      ctl_abort_o    <= init_go;
      status_valid_o <= 1'b1;
      mech_seek_o    <= 1'b0;
      mech_read_o    <= 1'b0;
      tmo_q          <= busy ? tmo_q + 32'h00000001 : 32'h00000000;
      if (timeout) begin
        st_q        <= S_IDLE;
        head_load_o <= 1'b0;
      end else begin
        case (st_q)
          S_IDLE: begin
            if (init_go) begin
              head_load_o <= 1'b1;
              // RULE_02 drive 1 only if present
              st_q <= d1_s_q[1] ? S_SEEK : S_READ;
            end
          end
          S_SEEK: begin
            mech_seek_o  <= 1'b1;
            mech_unit_o  <= `FHI_SEEK_UNIT;
            mech_track_o <= `FHI_SEEK_TRACK;
            st_q         <= S_SEEKW;
          end
          S_SEEKW: begin
            if (mech_done_i)
              st_q <= S_READ;
          end
          S_READ: begin
            mech_read_o   <= 1'b1;
            mech_unit_o   <= `FHI_READ_UNIT;
            mech_track_o  <= `FHI_READ_TRACK;
            mech_sector_o <= `FHI_READ_SECTOR;
            st_q          <= S_READW;
          end
          S_READW: begin
            // Failed read waits for the watchdog
            if (mech_done_i & mech_ok_i)
              st_q <= S_FIN;
          end
          S_FIN: begin
            st_q <= S_IDLE;
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // fhi_top

/* test_floppy_host_interface.sv */
// Purpose: self-checking bench for fhi_top
// Assumes: answers land one edge after the strobe
// Notes:   short init timeout keeps the run brief
`timescale 1ns/10ps
module test_floppy_host_interface;
  reg         clk_i = 0, reset_i = 1, iot_strobe_i = 0, pwr_ok_i = 1;
  reg         ctl_word_req_i = 0, ctl_dir_out_i = 0, ctl_word_load_i = 0, ctl_fn_start_i = 0;
  reg         ctl_clr_deleted_i = 0, ctl_fn_end_i = 0, ctl_read_status_i = 0;
  reg         ctl_crc_err_i = 0, ctl_parity_err_i = 0, ctl_deleted_i = 0, ctl_fail_i = 0;
  reg  [2:0]  iot_code_i = 0;
  reg  [11:0] ac_i = 0, ctl_word_i = 0, ao;
  reg         sk, al, pr, cm;
  reg         rdy_cfg = 1, d1_cfg = 1, fail_cfg = 0;
  wire [11:0] ac_o, ifr_o, status_o;
  wire        ac_load_o, skip_o, irq_o, ctl_proceed_o, ctl_cmd_o, ctl_mode8_o, ctl_abort_o;
  wire        status_valid_o, drive_ready_i, drv1_present_i, mech_done_i, mech_ok_i;
  wire        head_load_o, mech_seek_o, mech_read_o, mech_unit_o;
  wire [6:0]  mech_track_o;
  wire [4:0]  mech_sector_o;
  integer     err_total = 0, n_compared = 0, i, n_seek = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (mech_seek_o === 1'b1) n_seek <= n_seek + 1;
  fhi_top #(.INIT_CYC(200)) fhi_top_i (.clk_i, .reset_i, .iot_strobe_i, .iot_code_i, .ac_i,
    .ac_o, .ac_load_o, .skip_o, .irq_o, .ctl_word_req_i, .ctl_dir_out_i, .ctl_word_load_i,
    .ctl_word_i, .ctl_fn_start_i, .ctl_clr_deleted_i, .ctl_fn_end_i, .ctl_read_status_i,
    .ctl_crc_err_i, .ctl_parity_err_i, .ctl_deleted_i, .ctl_fail_i, .ctl_proceed_o,
    .ctl_cmd_o, .ctl_mode8_o, .ctl_abort_o, .ifr_o, .status_o, .status_valid_o, .pwr_ok_i,
    .drive_ready_i, .drv1_present_i, .mech_done_i, .mech_ok_i, .head_load_o, .mech_seek_o,
    .mech_read_o, .mech_unit_o, .mech_track_o, .mech_sector_o);
  fhi_mech_model fhi_mech_model_i (.clk_i, .reset_i, .ready_cfg_i(rdy_cfg),
    .present_cfg_i(d1_cfg), .fail_cfg_i(fail_cfg), .mech_seek_o, .mech_read_o,
    .mech_done_i, .mech_ok_i, .drive_ready_i, .drv1_present_i);
  task tally_and_finish;
    begin
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [11:0] e, input [11:0] g);
    begin
      n_compared = n_compared + 1;
      if (e !== g) begin
        err_total = err_total + 1;
        $display("Error %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task iot(input [2:0] c, input [11:0] a);
    begin
      @(negedge clk_i);
      {iot_strobe_i, iot_code_i, ac_i} = {1'b1, c, a};
      @(posedge clk_i);
      #1 {sk, al, pr, cm, ao} = {skip_o, ac_load_o, ctl_proceed_o, ctl_cmd_o, ac_o};
      @(negedge clk_i);
      iot_strobe_i = 0;
    end
  endtask
  // Levels: read status, crc, parity, deleted, fail
  task fend(input [4:0] f);
    begin
      @(negedge clk_i);
      {ctl_read_status_i, ctl_crc_err_i, ctl_parity_err_i, ctl_deleted_i, ctl_fail_i} = f;
      ctl_fn_end_i = 1;
      @(negedge clk_i);
      ctl_fn_end_i = 0;
      @(negedge clk_i);
    end
  endtask
  task wload(input [11:0] w);
    begin
      @(negedge clk_i);
      {ctl_word_load_i, ctl_word_i} = {1'b1, w};
      @(negedge clk_i);
      ctl_word_load_i = 0;
    end
  endtask
  task wdone;
    begin
      sk = 0;
      for (i = 0; i < 300 && sk !== 1'b1; i = i + 1) iot(3'h5, 12'h000);
      chk("done", 12'h001, sk);
    end
  endtask
  initial begin
    #500000;
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i) reset_i = 0;
    wdone;
    chk("initbit", 12'h001, status_o[2]);
    fend(5'h10); chk("rdstat", 12'h000, ifr_o[2]);
    chk("ready", 12'h001, status_o[7]);
    iot(3'h6, 12'h001); fend(5'h08); chk("crc", 12'h001, status_o[0]);
    chk("irq", 12'h001, irq_o);
    ctl_dir_out_i = 1; iot(3'h2, 12'h000); chk("stat_ac", 12'h001, ao[0]);
    chk("noproc", 12'h000, pr);
    chk("acld", 12'h001, al);
    iot(3'h4, 12'h000); chk("skerr", 12'h001, sk);
    iot(3'h4, 12'h000); chk("skerr2", 12'h000, sk);
    iot(3'h5, 12'h000); chk("skdone", 12'h001, sk);
    @(negedge clk_i); chk("irqclr", 12'h000, irq_o);
    fend(5'h04); chk("parity", 12'h001, status_o[1]);
    chk("errdone", 12'h001, irq_o);
    iot(3'h6, 12'h000); @(negedge clk_i); chk("irqoff", 12'h000, irq_o);
    iot(3'h4, 12'h000); iot(3'h5, 12'h000); chk("skdone", 12'h001, sk);
    fend(5'h02); chk("deleted", 12'h001, status_o[6]);
    @(negedge clk_i) {ctl_fn_start_i, ctl_clr_deleted_i} = 2'h3;
    @(negedge clk_i) ctl_fn_start_i = 0;
    chk("delclr", 12'h000, status_o[6]);
    iot(3'h5, 12'h000);
    for (i = 0; i < 2; i = i + 1) begin
      @(negedge clk_i) ctl_word_req_i = 1;
      @(negedge clk_i) ctl_word_req_i = 0;
      iot(3'h3, 12'h000); chk("wreq", 12'h001, sk);
      iot(3'h3, 12'h000); chk("wreqclr", 12'h000, sk);
    end
    iot(3'h1, 12'h020); chk("mode8", 12'h001, ctl_mode8_o);
    chk("cmd", 12'h001, cm);
    ctl_dir_out_i = 0; iot(3'h2, 12'hA5C); chk("proc", 12'h001, pr);
    chk("acld0", 12'h000, al);
    chk("ac_kept", 12'hA5C, ao); chk("ifr", 12'hA5C, ifr_o);
    ctl_dir_out_i = 1; wload(12'h3C3); iot(3'h2, 12'h50C); chk("or8", 12'h5CF, ao);
    iot(3'h1, 12'h000); wload(12'h3C3); iot(3'h2, 12'h50C); chk("jam", 12'h3C3, ao);
    fend(5'h08); iot(3'h4, 12'h000); iot(3'h5, 12'h000);
    @(negedge clk_i) ctl_fn_start_i = 1;
    @(negedge clk_i) ctl_fn_start_i = 0;
    fend(5'h00); chk("retry", 12'h000, status_o[0]);
    iot(3'h7, 12'h000); wdone;
    chk("zeroed", 12'h004, status_o & 12'h047);
    @(negedge clk_i) pwr_ok_i = 0;
    repeat (4) @(negedge clk_i);
    chk("invalid", 12'h000, {status_valid_o, head_load_o});
    chk("abort", 12'h001, ctl_abort_o);
    pwr_ok_i = 1; repeat (4) @(negedge clk_i); wdone;
    chk("rdunit", 12'h000, mech_unit_o); chk("rdtrk", 12'h001, mech_track_o);
    chk("rdsec", 12'h001, mech_sector_o); chk("seeks", 12'h003, n_seek[11:0]);
    {rdy_cfg, d1_cfg, fail_cfg} = 3'h1;
    repeat (3) @(negedge clk_i);
    iot(3'h7, 12'h000); wdone;
    chk("tmostat", 12'h000, status_o & 12'h084);
    iot(3'h4, 12'h000); chk("tmoerr", 12'h001, sk);
    chk("noseek", 12'h003, n_seek[11:0]);
    fend(5'h01); iot(3'h4, 12'h000); chk("failerr", 12'h001, sk);
    tally_and_finish;
  end
endmodule // test_floppy_host_interface
